// ==== rtl/sensor_port_map.svh ====
// Register offsets, field positions, reset values and timing counts of the sensor port block
`ifndef SENSOR_PORT_MAP_SVH
`define SENSOR_PORT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (5-bit register field of the serial command byte)
// ----------------------------------------------------------------------------
`define LED_PIN_FUNCTION_CTRL_OFS 5'h0e
`define TRANSMIT_TRIGGER_OFS 5'h0f
`define LINE_A_DRIVER_CONFIG_OFS 5'h10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LED_PIN_FUNCTION_CTRL_RST 8'h00
`define TRANSMIT_TRIGGER_RST 8'h00
`define LINE_A_DRIVER_CONFIG_RST 8'h00

// ----------------------------------------------------------------------------
// Pin function control fields
// ----------------------------------------------------------------------------
`define READY_PIN_SELECT_A_BIT 0
`define LED1_ON_A_BIT 1
`define ERR_PIN_SELECT_A_BIT 2
`define LED2_ON_A_BIT 3

// ----------------------------------------------------------------------------
// Trigger fields
// ----------------------------------------------------------------------------
`define TRIGGER_VALUE_MSB 3
`define TRIGGER_VALUE_LSB 0

// ----------------------------------------------------------------------------
// Line driver configuration fields
// ----------------------------------------------------------------------------
`define GLITCH_FILTER_ON_A_BIT 0
`define DRIVER_OFF_A_BIT 1
`define PUSH_PULL_SEL_A_BIT 2
`define LOW_SIDE_MODE_A_BIT 3
`define CURRENT_LEVEL_A_LSB 4
`define CURRENT_LEVEL_A_MSB 5
`define CURRENT_DIR_SEL_A_BIT 6
`define THRESHOLD_TYPE_SEL_A_BIT 7

// ----------------------------------------------------------------------------
// Serial command byte fields
// ----------------------------------------------------------------------------
`define CMD_READ_BIT 7
`define CMD_CHIP_MSB 6
`define CMD_CHIP_LSB 5
`define CMD_REG_MSB 4
`define CMD_REG_LSB 0
`define SPI_LAST_CMD_BIT 4'h7
`define SPI_LAST_DATA_BIT 4'hf

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLOCK_PERIOD_PS 5000
`define GLITCH_TIME_NS 1300
`define GLITCH_CYCLES ((`GLITCH_TIME_NS * 1000) / `CLOCK_PERIOD_PS)

`endif

// ==== rtl/sensor_port_pkg.sv ====
// Types shared by the sensor port configuration and trigger block
package sensor_port_pkg;
    // Serial frame phase
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_cmd = 2'b01,
        st_data = 2'b10
    } spi_state_type;

    // Current sink/source level encoding
    typedef enum logic [1:0] {
        lvl_off = 2'b00,
        lvl_5ma = 2'b01,
        lvl_2ma = 2'b10,
        lvl_150ua = 2'b11
    } current_level_type;
endpackage

// ==== rtl/pin_sync.sv ====
// Two-flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage, bit by bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_q[i] <= 1'b0;
                    pin_sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= pin_in[i];
                    pin_sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

// ==== rtl/sensor_port_cfg_trigger_regs.sv ====
// Channel A pin function, shared transmit trigger and line driver configuration
`timescale 1ns/1ps
`include "sensor_port_map.svh"

module sensor_port_cfg_trigger_regs
    import sensor_port_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial register port pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_q,
    output logic spi_miso_oe_n_q,
    // Chip address straps
    input wire logic [1:0] chip_addr_pins,
    // Channel A receive status from the framer
    input wire logic rx_error_flag_a,
    input wire logic rx_data_ready_flag_a,
    // Status pins of channel A
    output logic err_led2_pin_a_q,
    output logic ready_led1_pin_a_q,
    // Trigger assignment and cycle timer enables per channel
    input wire logic [3:0] assigned_trigger_a,
    input wire logic [3:0] assigned_trigger_b,
    input wire logic cycle_timer_en_a,
    input wire logic cycle_timer_en_b,
    // Start pulses per channel
    output logic start_cycle_timer_a_q,
    output logic start_master_msg_a_q,
    output logic start_cycle_timer_b_q,
    output logic start_master_msg_b_q,
    // Line pin of channel A
    input wire logic line_tx_a,
    input wire logic line_pin_a_in,
    output logic line_pin_a_out_q,
    output logic line_pin_a_oe_n_q,
    output logic line_rx_a_q,
    // Analogue front end settings of channel A
    output logic threshold_type_sel_a_q,
    output logic [1:0] source_level_a_q,
    output logic [1:0] sink_level_a_q
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam logic [8:0] GLITCH_CYCLES = 9'(`GLITCH_CYCLES);

    logic [5:0] sync_q;
    logic sclk_s, cs_n_s, mosi_s, line_in_s;
    logic [1:0] strap_s;
    logic sclk_prev_q;
    logic sclk_rise, sclk_fall;
    spi_state_type state_q;
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_in_q;
    logic [7:0] cmd_q;
    logic [7:0] rd_shift_q;
    logic [7:0] byte_in;
    logic [1:0] chip_addr_q;
    logic [1:0] strap_wait_q;
    logic own_chip;
    logic wr_strobe;
    logic [7:0] led_ctrl_q;
    logic [7:0] trigger_q;
    logic [7:0] cfg_q;
    logic trig_wr;
    logic [8:0] filt_cnt_q;

    // Register hit check, shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] cmd, input logic [4:0] ofs);
        reg_hit = (cmd[`CMD_REG_MSB:`CMD_REG_LSB] == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    pin_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .pin_in({chip_addr_pins, line_pin_a_in, spi_mosi, spi_cs_n, spi_sclk}),
        .pin_sync_q(sync_q)
    );

    assign sclk_s = sync_q[0];
    assign cs_n_s = sync_q[1];
    assign mosi_s = sync_q[2];
    assign line_in_s = sync_q[3];
    assign strap_s = sync_q[5:4];

    // Straps are followed for three edges after release, so the last copy comes
    // from a synchroniser that has left its reset value, then frozen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chip_addr_q <= 2'h0;
            strap_wait_q <= 2'h0;
        end else if (strap_wait_q != 2'h3) begin
            chip_addr_q <= strap_s;
            strap_wait_q <= strap_wait_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Serial register port, mode 0, 16-bit frames MSB first
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
    assign byte_in = {shift_in_q, mosi_s};
    assign own_chip = (cmd_q[`CMD_CHIP_MSB:`CMD_CHIP_LSB] == chip_addr_q);
    // Last data bit of a write frame
    assign wr_strobe = sclk_rise && (state_q == st_data) && !cmd_q[`CMD_READ_BIT]
        && (bit_cnt_q == `SPI_LAST_DATA_BIT);
    // Trigger writes are broadcast, so the chip address is not checked
    assign trig_wr = wr_strobe && reg_hit(cmd_q, `TRANSMIT_TRIGGER_OFS);

    // Frame phase and bit counting; a frame cut short by chip select is dropped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
            bit_cnt_q <= 4'h0;
            shift_in_q <= 7'h00;
            cmd_q <= 8'h00;
        end else if (cs_n_s) begin
            state_q <= st_idle;
            bit_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                st_idle: begin
                    state_q <= st_cmd;
                end
                st_cmd: begin
                    if (sclk_rise) begin
                        shift_in_q <= byte_in[6:0];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == `SPI_LAST_CMD_BIT) begin
                            cmd_q <= byte_in;
                            state_q <= st_data;
                        end
                    end
                end
                st_data: begin
                    if (sclk_rise) begin
                        shift_in_q <= byte_in[6:0];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == `SPI_LAST_DATA_BIT) begin
                            state_q <= st_cmd;
                        end
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // Read data is loaded after the command byte and shifted out on falling edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_shift_q <= 8'h00;
            spi_miso_q <= 1'b0;
        end else if (sclk_rise && state_q == st_cmd && bit_cnt_q == `SPI_LAST_CMD_BIT) begin
            // Write-only trigger and unmapped offsets read as zero
            if (byte_in[`CMD_CHIP_MSB:`CMD_CHIP_LSB] != chip_addr_q) begin
                rd_shift_q <= 8'h00;
            end else if (reg_hit(byte_in, `LED_PIN_FUNCTION_CTRL_OFS)) begin
                rd_shift_q <= led_ctrl_q;
            end else if (reg_hit(byte_in, `LINE_A_DRIVER_CONFIG_OFS)) begin
                rd_shift_q <= cfg_q;
            end else begin
                rd_shift_q <= 8'h00;
            end
        end else if (sclk_fall && state_q == st_data) begin
            spi_miso_q <= rd_shift_q[7];
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
        end
    end

    // Data output is driven only while this chip is selected
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            spi_miso_oe_n_q <= 1'b1;
        end else begin
            spi_miso_oe_n_q <= cs_n_s;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Pin function control, all eight bits writable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            led_ctrl_q <= `LED_PIN_FUNCTION_CTRL_RST;
        end else if (wr_strobe && own_chip && reg_hit(cmd_q, `LED_PIN_FUNCTION_CTRL_OFS)) begin
            led_ctrl_q <= byte_in;
        end
    end

    // Trigger keeps only the low nibble; the upper bits stay zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trigger_q <= `TRANSMIT_TRIGGER_RST;
        end else if (trig_wr) begin
            trigger_q <= {4'h0, byte_in[`TRIGGER_VALUE_MSB:`TRIGGER_VALUE_LSB]};
        end
    end

    // Line driver configuration
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_q <= `LINE_A_DRIVER_CONFIG_RST;
        end else if (wr_strobe && own_chip && reg_hit(cmd_q, `LINE_A_DRIVER_CONFIG_OFS)) begin
            cfg_q <= byte_in;
        end
    end

    // ------------------------------------------------------------------------
    // Trigger start pulses
    // ------------------------------------------------------------------------
    // One-cycle starts on the write itself; a channel with no match sees nothing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_cycle_timer_a_q <= 1'b0;
            start_master_msg_a_q <= 1'b0;
            start_cycle_timer_b_q <= 1'b0;
            start_master_msg_b_q <= 1'b0;
        end else begin
            start_master_msg_a_q <= trig_wr && (byte_in[3:0] == assigned_trigger_a);
            start_cycle_timer_a_q <= trig_wr && (byte_in[3:0] == assigned_trigger_a)
                && cycle_timer_en_a;
            start_master_msg_b_q <= trig_wr && (byte_in[3:0] == assigned_trigger_b);
            start_cycle_timer_b_q <= trig_wr && (byte_in[3:0] == assigned_trigger_b)
                && cycle_timer_en_b;
        end
    end

    // ------------------------------------------------------------------------
    // Status and LED pins
    // ------------------------------------------------------------------------
    // Interrupt masks are not consulted here, so masking never hides the pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_led2_pin_a_q <= 1'b0;
            ready_led1_pin_a_q <= 1'b0;
        end else begin
            err_led2_pin_a_q <= led_ctrl_q[`ERR_PIN_SELECT_A_BIT] ? rx_error_flag_a
                : led_ctrl_q[`LED2_ON_A_BIT];
            ready_led1_pin_a_q <= led_ctrl_q[`READY_PIN_SELECT_A_BIT]
                ? rx_data_ready_flag_a
                : led_ctrl_q[`LED1_ON_A_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Line driver and front end
    // ------------------------------------------------------------------------
    // Open-drain modes drive only one level; the other is left to the load
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_pin_a_out_q <= 1'b0;
            line_pin_a_oe_n_q <= 1'b1;
        end else if (cfg_q[`DRIVER_OFF_A_BIT]) begin
            line_pin_a_out_q <= 1'b0;
            line_pin_a_oe_n_q <= 1'b1;
        end else if (cfg_q[`PUSH_PULL_SEL_A_BIT]) begin
            line_pin_a_out_q <= line_tx_a;
            line_pin_a_oe_n_q <= 1'b0;
        end else if (cfg_q[`LOW_SIDE_MODE_A_BIT]) begin
            line_pin_a_out_q <= 1'b0;
            line_pin_a_oe_n_q <= line_tx_a;
        end else begin
            line_pin_a_out_q <= 1'b1;
            line_pin_a_oe_n_q <= ~line_tx_a;
        end
    end

    // Level goes to the selected current direction only, the other is off
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            threshold_type_sel_a_q <= 1'b0;
            source_level_a_q <= lvl_off;
            sink_level_a_q <= lvl_off;
        end else begin
            threshold_type_sel_a_q <= cfg_q[`THRESHOLD_TYPE_SEL_A_BIT];
            source_level_a_q <= cfg_q[`CURRENT_DIR_SEL_A_BIT]
                ? cfg_q[`CURRENT_LEVEL_A_MSB:`CURRENT_LEVEL_A_LSB] : lvl_off;
            sink_level_a_q <= cfg_q[`CURRENT_DIR_SEL_A_BIT]
                ? lvl_off : cfg_q[`CURRENT_LEVEL_A_MSB:`CURRENT_LEVEL_A_LSB];
        end
    end

    // Glitch filter: a new level must hold for the filter time before it passes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_rx_a_q <= 1'b0;
            filt_cnt_q <= 9'h000;
        end else if (!cfg_q[`GLITCH_FILTER_ON_A_BIT] || line_in_s == line_rx_a_q) begin
            line_rx_a_q <= line_in_s;
            filt_cnt_q <= 9'h000;
        end else if (filt_cnt_q == GLITCH_CYCLES - 9'h001) begin
            line_rx_a_q <= line_in_s;
            filt_cnt_q <= 9'h000;
        end else begin
            filt_cnt_q <= filt_cnt_q + 9'h001;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_err_pin_error: assert property (
        led_ctrl_q[`ERR_PIN_SELECT_A_BIT] && $stable(led_ctrl_q) |=>
            err_led2_pin_a_q == $past(rx_error_flag_a))
        else $error("error pin does not follow receive error");
    chk_err_pin_led: assert property (
        !led_ctrl_q[`ERR_PIN_SELECT_A_BIT] ##1 !led_ctrl_q[`ERR_PIN_SELECT_A_BIT] |->
            err_led2_pin_a_q == $past(led_ctrl_q[`LED2_ON_A_BIT]))
        else $error("error pin does not follow LED2 control");
    chk_ready_pin_mode: assert property (
        ##1 ready_led1_pin_a_q == ($past(led_ctrl_q[`READY_PIN_SELECT_A_BIT])
            ? $past(rx_data_ready_flag_a) : $past(led_ctrl_q[`LED1_ON_A_BIT])))
        else $error("ready pin wrong for selected function");
    chk_trigger_upper_zero: assert property (
        trigger_q[7:4] == 4'h0)
        else $error("trigger upper bits not zero");
    chk_trigger_start_a: assert property (
        trig_wr && byte_in[3:0] == assigned_trigger_a |=>
            start_master_msg_a_q && start_cycle_timer_a_q == $past(cycle_timer_en_a)
            ##1 !start_master_msg_a_q)
        else $error("matching trigger did not pulse channel A start");
    chk_trigger_nomatch: assert property (
        !(trig_wr && byte_in[3:0] == assigned_trigger_b) |=>
            !start_master_msg_b_q && !start_cycle_timer_b_q)
        else $error("channel B started without matching trigger");
    chk_driver_off_hiz: assert property (
        cfg_q[`DRIVER_OFF_A_BIT] ##1 cfg_q[`DRIVER_OFF_A_BIT] |-> line_pin_a_oe_n_q)
        else $error("line driven while driver disabled");
    chk_push_pull_drive: assert property (
        cfg_q[2:1] == 2'b10 |=> !line_pin_a_oe_n_q && line_pin_a_out_q == $past(line_tx_a))
        else $error("push-pull mode does not drive the line");
    chk_level_routing: assert property (
        ##1 (source_level_a_q | sink_level_a_q) == $past(cfg_q[5:4])
            && (source_level_a_q == 2'b00 || sink_level_a_q == 2'b00))
        else $error("current level routed wrongly");
    chk_filter_hold: assert property (
        cfg_q[`GLITCH_FILTER_ON_A_BIT] && filt_cnt_q < GLITCH_CYCLES - 9'h001 |=>
            $stable(line_rx_a_q))
        else $error("filtered receiver changed too early");

    cov_trigger_match: cover property (trig_wr ##1 start_master_msg_a_q);
    cov_err_mode: cover property (led_ctrl_q[`ERR_PIN_SELECT_A_BIT] && err_led2_pin_a_q);
    cov_filter_pass: cover property (filt_cnt_q == GLITCH_CYCLES - 9'h001);
endmodule

// ==== dv/spi_master_model.sv ====
// Serial register port master standing in for the controlling microcontroller
`timescale 1ns/1ps
module spi_master_model #(
    parameter int HALF = 6
) (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso_q
);
    // Idle bus: clock low, deselected
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // One 16-bit mode 0 frame; half periods stay well above the 3-clock minimum
    // so the synchronised sampler never misses an edge
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clock) spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clock) spi_mosi <= frame[i];
            repeat (HALF) @(posedge clock);
            if (i < 8) rd = {rd[6:0], spi_miso_q}; // Read data taken at our own rise
            spi_sclk <= 1'b1;
            repeat (HALF) @(posedge clock);
            spi_sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
        spi_cs_n <= 1'b1;
        repeat (HALF) @(posedge clock);
    endtask
endmodule

// ==== dv/sensor_port_cfg_trigger_regs_tb.sv ====
// Self-checking bench for the pin function, trigger and line driver registers
`timescale 1ns/1ps
module sensor_port_cfg_trigger_regs_tb;
    import sensor_port_pkg::*;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic clock = 1'b0, rst = 1'b1, spi_sclk, spi_cs_n, spi_mosi, spi_miso_q, spi_miso_oe_n_q;
    logic [1:0] chip_addr_pins = 2'b01;
    logic rx_error_flag_a = 1'b0, rx_data_ready_flag_a = 1'b0, line_tx_a = 1'b0;
    logic [3:0] assigned_trigger_a = 4'h5, assigned_trigger_b = 4'h5;
    logic cycle_timer_en_a = 1'b1, cycle_timer_en_b = 1'b0, line_pin_a_in = 1'b0;
    logic err_led2_pin_a_q, ready_led1_pin_a_q, line_pin_a_out_q, line_pin_a_oe_n_q;
    logic line_rx_a_q, threshold_type_sel_a_q;
    logic start_cycle_timer_a_q, start_master_msg_a_q, start_cycle_timer_b_q, start_master_msg_b_q;
    logic [1:0] source_level_a_q, sink_level_a_q, n_ma, n_ta, n_mb, n_tb;
    logic [7:0] rd_byte;
    logic [24:0] rows [16], r;
    int err_total = 0, compares = 0;
    wire [8:0] pins = {err_led2_pin_a_q, ready_led1_pin_a_q, line_pin_a_oe_n_q, line_pin_a_out_q,
                       threshold_type_sel_a_q, source_level_a_q, sink_level_a_q};

    sensor_port_cfg_trigger_regs u_sensor_port_cfg_trigger_regs (.*);
    spi_master_model u_spi_master_model (.clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso_q(spi_miso_q));

    // Clock and start-pulse cycle counters; a stretched pulse shows up as an extra count
    always #2.5 clock = ~clock;
    // Cleared by reset so the unknown pulse levels before the first edge never count
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            {n_ma, n_ta, n_mb, n_tb} <= 8'h00;
        end else begin
            n_ma <= n_ma + start_master_msg_a_q;
            n_ta <= n_ta + start_cycle_timer_a_q;
            n_mb <= n_mb + start_master_msg_b_q;
            n_tb <= n_tb + start_cycle_timer_b_q;
        end
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic spi(input logic rnw, input logic [1:0] chip, input logic [4:0] ofs,
                       input logic [7:0] d);
        u_spi_master_model.xfer({rnw, chip, ofs, d}, rd_byte);
    endtask

    task automatic final_report();
        if (err_total == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog far beyond the roughly 11k clocks the sequence needs
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        // Offset, data, line tx, {error, ready} flags, expected pins
        rows = '{{5'h0e, 8'h0a, 1'b0, 2'b00, 9'h1e0}, {5'h0e, 8'h0a, 1'b0, 2'b11, 9'h1e0},
                 {5'h0e, 8'h05, 1'b1, 2'b11, 9'h1a0}, {5'h0e, 8'h0f, 1'b1, 2'b00, 9'h020},
                 {5'h0e, 8'h05, 1'b1, 2'b10, 9'h120}, {5'h0e, 8'h05, 1'b1, 2'b01, 9'h0a0},
                 {5'h0e, 8'h00, 1'b1, 2'b11, 9'h020}, {5'h10, 8'h04, 1'b1, 2'b00, 9'h020},
                 {5'h10, 8'h0c, 1'b0, 2'b00, 9'h000}, {5'h10, 8'h08, 1'b0, 2'b00, 9'h000},
                 {5'h10, 8'h08, 1'b1, 2'b00, 9'h040}, {5'h10, 8'h06, 1'b1, 2'b00, 9'h040},
                 {5'h10, 8'h52, 1'b1, 2'b00, 9'h044}, {5'h10, 8'ha2, 1'b1, 2'b00, 9'h052},
                 {5'h10, 8'h72, 1'b1, 2'b00, 9'h04c}, {5'h10, 8'h32, 1'b1, 2'b00, 9'h043}};
        @(negedge clock) check(pins, 9'h040); // Held in reset: line undriven, pins low
        check({8'h00, spi_miso_oe_n_q}, 9'h001); // Data output released in reset
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        // Table of pin function and line driver settings, each read back afterwards
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            @(posedge clock);
            line_tx_a <= r[11];
            {rx_error_flag_a, rx_data_ready_flag_a} <= r[10:9];
            spi(1'b0, 2'b01, r[24:20], r[19:12]);
            repeat (4) @(posedge clock);
            @(negedge clock) check({7'h00, pins[8:7]}, {7'h00, r[8:7]});
            check({2'b00, pins[6:0]}, {2'b00, r[6:0]});
            spi(1'b1, 2'b01, r[24:20], 8'h00);
            check({1'b0, rd_byte}, {1'b0, r[19:12]}); // Stored value reads back
        end
        // Another chip's write is ignored; unmapped and trigger offsets read zero
        spi(1'b0, 2'b10, 5'h10, 8'hff);
        spi(1'b1, 2'b01, 5'h10, 8'h00);
        check({1'b0, rd_byte}, 9'h032); // Foreign chip address refused
        spi(1'b1, 2'b01, 5'h1f, 8'h00);
        check({1'b0, rd_byte}, 9'h000); // Unmapped offset
        // Trigger broadcast under a foreign address, upper bits set and not compared
        spi(1'b0, 2'b10, 5'h0f, 8'hf5);
        repeat (4) @(posedge clock);
        check({1'b0, n_ma, n_ta, n_mb, n_tb}, 9'h054);
        spi(1'b0, 2'b01, 5'h0f, 8'h03);
        repeat (4) @(posedge clock);
        check({1'b0, n_ma, n_ta, n_mb, n_tb}, 9'h054);
        assigned_trigger_b <= 4'h3;
        cycle_timer_en_b <= 1'b1;
        spi(1'b0, 2'b01, 5'h0f, 8'h03);
        repeat (4) @(posedge clock);
        check({1'b0, n_ma, n_ta, n_mb, n_tb}, 9'h059);
        spi(1'b1, 2'b01, 5'h0f, 8'h00);
        check({1'b0, rd_byte}, 9'h000);
        // Glitch filter: a 200-clock burst is swallowed, a 280-clock level passes
        spi(1'b0, 2'b01, 5'h10, 8'h01);
        line_pin_a_in <= 1'b1;
        repeat (200) @(posedge clock);
        check({8'h00, line_rx_a_q}, 9'h000);
        line_pin_a_in <= 1'b0;
        repeat (20) @(posedge clock);
        line_pin_a_in <= 1'b1;
        repeat (250) @(posedge clock);
        check({8'h00, line_rx_a_q}, 9'h000);
        repeat (30) @(posedge clock);
        check({8'h00, line_rx_a_q}, 9'h001);
        spi(1'b0, 2'b01, 5'h10, 8'h00);
        line_pin_a_in <= 1'b0;
        repeat (6) @(posedge clock);
        check({8'h00, line_rx_a_q}, 9'h000);
        // Reset in mid-run clears the registers and the straps are caught again
        spi(1'b0, 2'b01, 5'h0e, 8'h0a);
        rst <= 1'b1;
        @(negedge clock) check(pins, 9'h040); // Pins back at reset levels
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
        spi(1'b1, 2'b01, 5'h0e, 8'h00);
        check({1'b0, rd_byte}, 9'h000); // Register back at reset value
        spi(1'b0, 2'b01, 5'h0e, 8'h0a);
        spi(1'b1, 2'b01, 5'h0e, 8'h00);
        check({1'b0, rd_byte}, 9'h00a); // Own address taken again after reset
        final_report();
    end
endmodule
